/* File: core/sslc_pkg.sv */
// constants and types of the spindle speed loop controller
`default_nettype none
package sslc_pkg;
	// ----------------------------------------------------------------
	// timing and loop constants
	// ----------------------------------------------------------------
	localparam int CLK_HZ       = 32'h0EE6_B280;          // 250 MHz
	localparam int REF_HZ       = 32'h001E_8480;          // 2 MHz reference
	localparam int REF_MIN_HZ   = 32'h0000_0064;          // 100 Hz slowest ref
	localparam int STALL_MIN_MS = 32'h0000_0352;          // 850 ms least
	localparam int STALL_MAX_MS = 32'h0000_0384;          // 900 ms most
	localparam int CNT_PRESET   = 32'h0000_8238;          // 33336 ticks per rev
	localparam int REV_SHUT_RPM = 32'h0000_0064;          // reverse shutdown speed
	// ref ticks to stall, least time rounds up
	localparam int STALL_TICKS  = (STALL_MIN_MS * (REF_HZ / 1000) + 0);
	// clk cycles without a ref edge, longest time rounds down
	localparam int REF_LOSS_CYC = CLK_HZ / (2 * REF_MIN_HZ);
	// ref ticks per revolution at reverse shutdown speed
	localparam int REV_SHUT_TICKS = (REF_HZ / REV_SHUT_RPM) * 60;
	localparam int CNT_W        = 32'h0000_0016;          // 22-bit signed counter
	localparam int PROP_MAX     = 32'h0000_003F;          // +63 linear limit
	localparam int PROP_MIN     = -32'sh0000_0040;        // -64 linear limit
	localparam int ACC_STEP     = 32'h0000_0100;          // addend clamp
	localparam int ACC_MAX      = 32'h0000_07FF;          // 12-bit accumulator
	localparam int CTRL_BIAS    = 32'h0000_0080;          // summer mid point
	localparam int CTRL_FULL    = 32'h0000_00FF;          // boost / start drive
	// ----------------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_STATE    = 8'h04;
	localparam logic [7:0] OFS_PERIOD   = 8'h08;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
	localparam logic [7:0] OFS_IRQ_CLR  = 8'h10;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h14;
	localparam logic       CTRL_RST     = 1'h1;               // drive enabled
	localparam int         IRQ_N        = 32'h0000_0006;
	// irq bits: 0 stall 1 supply 2 ref loss 3 lock 4 brake stop 5 index
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [5:0] prop;                               // proportional code
		logic [7:0] integ;                              // integral code
	} sslc_loop_t;
	typedef enum logic [1:0] {PH_NONE, PH_A, PH_B, PH_C} sslc_phase_t;
endpackage : sslc_pkg
`default_nettype wire

/* File: core/sslc_core.sv */
// spindle speed loop controller core with apb registers
`timescale 1ns/1ps
`default_nettype none
// Function
// [RL1] preset speed counter on every index pulse
// [RL2] next index: remainder to proportional, accumulate
// [RL3] integral converter from accumulator high bits
// [RL4] overflow decode clamps proportional code
// [RL5] overflow raises boost toward summer
// [RL6] accumulator range wider than proportional span
// [RL7] full counter doubles as timeout timer
// [RL8] no index within timeout means stall
// [RL9] stall holds current zero until index
// [RL10] fault high while stalled
// [RL11] low supply: drivers off, fault high
// [RL12] slow reference: drivers off, fault high
// [RL13] lock pulled low within linear range
// [RL14] brake input low reverses driver phasing
// [RL15] braking below shutdown speed: drivers off
// [RL16] host never brakes below minimum speed
// [RL17] hall state selects driven phase
// [RL18] preset equals ticks per target revolution
module sslc_core #(
	parameter int STALL_TICKS  = sslc_pkg::STALL_TICKS,
	parameter int REF_LOSS_CYC = sslc_pkg::REF_LOSS_CYC
) (
	input  wire logic               CLK,
	input  wire logic               RESETN,
	input  wire logic               PSEL,
	input  wire logic               PENABLE,
	input  wire logic               PWRITE,
	input  wire logic [7:0]         PADDR,
	input  wire logic [31:0]        PWDATA,
	output logic [31:0]             PRDATA,
	output logic                    PREADY,
	output logic                    PSLVERR,
	input  wire logic               REFERENCE_CLOCK_IN,
	input  wire logic               INDEX_HALL_INPUT,
	input  wire logic               SECOND_HALL_INPUT,
	input  wire logic               THIRD_HALL_INPUT,
	input  wire logic               RUN_BRAKE,
	input  wire logic               SUPPLY_LOW,
	output logic                    HALL_BIAS_OUTPUT,
	output logic [7:0]              PHASE_A_DRIVE,
	output logic [7:0]              PHASE_B_DRIVE,
	output logic [7:0]              PHASE_C_DRIVE,
	output sslc_pkg::sslc_loop_t    LOOP_DAC,
	output logic                    BOOST,
	output logic                    FAULT,
	output logic                    LOCK_O,
	output logic                    LOCK_OE,
	output logic                    IRQ
);
	localparam int CW = sslc_pkg::CNT_W;
	localparam logic signed [CW-1:0] PRESET_S = CW'(sslc_pkg::CNT_PRESET);
	localparam logic signed [CW-1:0] FLOOR_S  = CW'(sslc_pkg::CNT_PRESET - STALL_TICKS);
	localparam logic signed [CW-1:0] REV_S    =
		CW'(sslc_pkg::CNT_PRESET - sslc_pkg::REV_SHUT_TICKS);
	localparam logic signed [CW-1:0] PMAX_S   = CW'(sslc_pkg::PROP_MAX);
	localparam logic signed [CW-1:0] PMIN_S   = CW'(sslc_pkg::PROP_MIN);
	localparam logic signed [CW-1:0] STEP_S   = CW'(sslc_pkg::ACC_STEP);
	localparam logic signed [12:0]   AMAX_S   = 13'(sslc_pkg::ACC_MAX);
	localparam logic [22:0]          LOSS_C   = 23'(REF_LOSS_CYC);

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [5:0] sync1_reg;                  // first stage, read only by second
	logic [5:0] sync2_reg;                  // {sup, run, h3, h2, h1, ref}
	logic       ref_prev_reg;               // for ref edge detect
	logic       h1_prev_reg;                // for index edge detect

	// two flops per pin, every pin is asynchronous to CLK
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			sync1_reg <= 6'h00;
			sync2_reg <= 6'h10;
		end else begin
			sync1_reg <= {SUPPLY_LOW, RUN_BRAKE, THIRD_HALL_INPUT,
				SECOND_HALL_INPUT, INDEX_HALL_INPUT, REFERENCE_CLOCK_IN};
			sync2_reg <= sync1_reg;
		end
	end

	// edge history taken from the second stage only
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			ref_prev_reg <= 1'b0;
			h1_prev_reg  <= 1'b0;
		end else begin
			ref_prev_reg <= sync2_reg[0];
			h1_prev_reg  <= sync2_reg[1];
		end
	end

	logic ref_tick;                         // one ref rising edge
	logic index;                            // rising index edge
	logic braking;                          // run/brake input low
	logic supply_bad;                       // low supply level
	assign ref_tick   = sync2_reg[0] & ~ref_prev_reg;
	assign index      = sync2_reg[1] & ~h1_prev_reg;
	assign braking    = ~sync2_reg[4];
	assign supply_bad = sync2_reg[5];

	// ----------------------------------------------------------------
	// speed counter and timeout
	// ----------------------------------------------------------------
	logic signed [CW-1:0] cnt_reg;          // counts down from preset
	logic                 at_floor;         // stall interval reached
	logic                 valid_reg;        // a measured revolution is held
	assign at_floor = (cnt_reg <= FLOOR_S);

	// reset doubles as power onset, so timing starts at once
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			cnt_reg <= PRESET_S;
		end else if (index) begin
			cnt_reg <= PRESET_S;                        // see RL1 see RL18
		end else if (ref_tick && !at_floor) begin
			cnt_reg <= cnt_reg - CW'(1);                // see RL7
		end
	end

	// the first index only starts a measurement
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			valid_reg <= 1'b0;
		end else if (index) begin
			valid_reg <= 1'b1;
		end else if (at_floor) begin
			valid_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// error decode, proportional and integral paths
	// ----------------------------------------------------------------
	logic                 fast;             // remainder above linear range
	logic                 slow;             // remainder below linear range
	logic signed [CW-1:0] addend;           // clamped accumulator input
	logic signed [12:0]   acc_sum;          // one bit of headroom
	logic signed [11:0]   acc_reg;          // saturating accumulator
	logic [5:0]           prop_reg;         // proportional code
	logic                 boost_reg;        // summer boost
	logic                 slow_reg;         // last decode was slow
	logic                 sample;           // index with a valid remainder
	assign fast   = (cnt_reg > PMAX_S);
	assign slow   = (cnt_reg < PMIN_S);
	assign sample = index & valid_reg;

	// small disturbances fill the wide accumulator before it saturates
	always_comb begin
		if (cnt_reg > STEP_S) begin
			addend = STEP_S;
		end else if (cnt_reg < -STEP_S) begin
			addend = -STEP_S;
		end else begin
			addend = cnt_reg;
		end
		acc_sum = 13'(acc_reg) + 13'(addend);
	end

	// proportional code clamps at the end it ran off
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			prop_reg <= 6'h00;
		end else if (sample) begin
			if (fast) begin
				prop_reg <= 6'h1F;                      // see RL4
			end else if (slow) begin
				prop_reg <= 6'h20;                      // see RL4
			end else begin
				prop_reg <= cnt_reg[6:1];               // see RL2
			end
		end
	end

	// saturating accumulation of the clamped remainder
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			acc_reg <= 12'h000;
		end else if (sample) begin
			if (acc_sum > AMAX_S) begin
				acc_reg <= 12'h7FF;                     // see RL6
			end else if (acc_sum < -AMAX_S - 13'sd1) begin
				acc_reg <= 12'h800;                     // see RL6
			end else begin
				acc_reg <= acc_sum[11:0];               // see RL2
			end
		end
	end

	// overflow flags held until the next revolution
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			boost_reg <= 1'b0;
			slow_reg  <= 1'b1;
		end else if (sample) begin
			boost_reg <= fast | slow;                   // see RL5
			slow_reg  <= slow;
		end
	end

	// ----------------------------------------------------------------
	// summer
	// ----------------------------------------------------------------
	logic signed [9:0] ctrl_s;              // bias minus both paths
	logic [7:0]        ctrl_reg;            // drive amplitude
	assign ctrl_s = 10'(sslc_pkg::CTRL_BIAS) - 10'(signed'(acc_reg[11:4])) - 10'(signed'(prop_reg));

	// slow decode, or none yet since reset, drives full scale: the start current
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			ctrl_reg <= 8'(sslc_pkg::CTRL_FULL);
		end else if (slow_reg) begin
			ctrl_reg <= 8'(sslc_pkg::CTRL_FULL);        // see RL5
		end else if (ctrl_s < 10'sd0) begin
			ctrl_reg <= 8'h00;
		end else if (ctrl_s > 10'(sslc_pkg::CTRL_FULL)) begin
			ctrl_reg <= 8'(sslc_pkg::CTRL_FULL);
		end else begin
			ctrl_reg <= ctrl_s[7:0];
		end
	end

	// ----------------------------------------------------------------
	// protection
	// ----------------------------------------------------------------
	logic        stall_reg;                 // stalled rotor
	logic [22:0] loss_cnt_reg;              // clk cycles since a ref edge
	logic        ref_loss_reg;              // reference too slow
	logic        brake_stop_reg;            // braking finished
	logic        lock_reg;                  // in linear range
	logic        fault_reg;                 // fault pin

	// index clears a stall: the counter restarts so no new hit that cycle
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			stall_reg <= 1'b0;
		end else if (index) begin
			stall_reg <= 1'b0;                          // see RL9
		end else if (at_floor) begin
			stall_reg <= 1'b1;                          // see RL8
		end
	end

	// any ref level change proves the reference alive
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			loss_cnt_reg <= 23'h00_0000;
			ref_loss_reg <= 1'b0;
		end else if (sync2_reg[0] != ref_prev_reg) begin
			loss_cnt_reg <= 23'h00_0000;
			ref_loss_reg <= 1'b0;
		end else if (loss_cnt_reg >= LOSS_C) begin
			ref_loss_reg <= 1'b1;                       // see RL12
		end else begin
			loss_cnt_reg <= loss_cnt_reg + 23'h00_0001;
		end
	end

	// caller keeps braking requests above the minimum speed, see RL16
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			brake_stop_reg <= 1'b0;
		end else if (!braking) begin
			brake_stop_reg <= 1'b0;
		end else if (cnt_reg <= REV_S) begin
			brake_stop_reg <= 1'b1;                     // see RL15
		end
	end

	// lock follows each decode, lost on stall
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			lock_reg <= 1'b0;
		end else if (at_floor) begin
			lock_reg <= 1'b0;
		end else if (sample) begin
			lock_reg <= ~(fast | slow);                 // see RL13
		end
	end

	// fault pin for stall, supply and reference loss
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			fault_reg <= 1'b0;
		end else begin
			fault_reg <= stall_reg | supply_bad | ref_loss_reg; // see RL10 see RL11
		end
	end

	// ----------------------------------------------------------------
	// commutation and drivers
	// ----------------------------------------------------------------
	logic                  ctrl_en_reg;     // software drive enable
	logic [2:0]            hall_eff;        // hall code after braking swap
	logic                  drv_off;         // all drivers off
	sslc_pkg::sslc_phase_t phase;           // selected driver
	assign hall_eff = braking ? ~sync2_reg[3:1] : sync2_reg[3:1]; // see RL14
	assign drv_off  = stall_reg | supply_bad | ref_loss_reg |
		brake_stop_reg | ~ctrl_en_reg;                  // see RL9 see RL11

	// inverted halls sit half a cycle on, giving reverse torque
	always_comb begin
		unique case (hall_eff)
			3'b001, 3'b011: phase = sslc_pkg::PH_A;     // see RL17
			3'b010, 3'b110: phase = sslc_pkg::PH_B;     // see RL17
			3'b100, 3'b101: phase = sslc_pkg::PH_C;     // see RL17
			default:        phase = sslc_pkg::PH_NONE;  // broken sensor
		endcase
	end

	// one phase carries the control voltage, the others rest
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			PHASE_A_DRIVE <= 8'h00;
			PHASE_B_DRIVE <= 8'h00;
			PHASE_C_DRIVE <= 8'h00;
		end else begin
			PHASE_A_DRIVE <= (!drv_off && phase == sslc_pkg::PH_A) ? ctrl_reg : 8'h00;
			PHASE_B_DRIVE <= (!drv_off && phase == sslc_pkg::PH_B) ? ctrl_reg : 8'h00;
			PHASE_C_DRIVE <= (!drv_off && phase == sslc_pkg::PH_C) ? ctrl_reg : 8'h00;
		end
	end

	assign LOOP_DAC.prop  = prop_reg;
	assign LOOP_DAC.integ = acc_reg[11:4];                  // see RL3
	assign BOOST          = boost_reg;
	assign FAULT          = fault_reg;
	assign LOCK_O         = 1'b0;
	assign LOCK_OE        = lock_reg;
	assign HALL_BIAS_OUTPUT = RESETN;

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	logic [5:0] irq_stat_reg;               // sticky events
	logic [5:0] irq_en_reg;                 // enables
	logic [5:0] ev;                         // event pulses
	logic [5:0] ev_prev_reg;                // level history
	logic [5:0] irq_clr;                    // write-one-to-clear
	logic       wr;                         // apb write access

	// levels become edge events so a held fault fires once
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			ev_prev_reg <= 6'h00;
		end else begin
			ev_prev_reg <= {index, brake_stop_reg, lock_reg,
				ref_loss_reg, supply_bad, stall_reg};
		end
	end
	assign ev = {index, brake_stop_reg, lock_reg, ref_loss_reg, supply_bad, stall_reg}
		& ~ev_prev_reg;
	assign irq_clr = (wr && PADDR == sslc_pkg::OFS_IRQ_CLR) ? PWDATA[5:0] : 6'h00;

	// a new event beats a clear in the same cycle
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			irq_stat_reg <= 6'h00;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | ev;
		end
	end
	assign IRQ = |(irq_stat_reg & irq_en_reg);

	// ----------------------------------------------------------------
	// apb slave, one access cycle, read data staged in setup
	// ----------------------------------------------------------------
	logic setup;                            // apb setup phase
	assign setup  = PSEL & ~PENABLE;
	assign wr     = PSEL & PENABLE & PWRITE;
	assign PREADY = PSEL & PENABLE;

	// software writes land at the access edge
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			ctrl_en_reg <= sslc_pkg::CTRL_RST;
			irq_en_reg  <= 6'h00;
		end else if (wr && PADDR == sslc_pkg::OFS_CTRL) begin
			ctrl_en_reg <= PWDATA[0];
		end else if (wr && PADDR == sslc_pkg::OFS_IRQ_EN) begin
			irq_en_reg <= PWDATA[5:0];
		end
	end

	// read mux and error decode, unmapped or wrong direction errs
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else if (setup) begin
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
			unique case (PADDR)
				sslc_pkg::OFS_CTRL:     PRDATA <= {31'h0, ctrl_en_reg};
				sslc_pkg::OFS_STATE:    PRDATA <= {21'h0, sync2_reg[3:1], braking,
					boost_reg, slow_reg, brake_stop_reg, ref_loss_reg, lock_reg,
					stall_reg, fault_reg};
				sslc_pkg::OFS_PERIOD:   PRDATA <= 32'(signed'(cnt_reg));
				sslc_pkg::OFS_IRQ_STAT: begin
					PRDATA  <= {26'h0, irq_stat_reg};
					PSLVERR <= PWRITE;
				end
				sslc_pkg::OFS_IRQ_CLR:  PSLVERR <= ~PWRITE;
				sslc_pkg::OFS_IRQ_EN:   PRDATA <= {26'h0, irq_en_reg};
				default:                PSLVERR <= 1'b1;
			endcase
			if (PWRITE && (PADDR == sslc_pkg::OFS_STATE
				|| PADDR == sslc_pkg::OFS_PERIOD)) begin
				PSLVERR <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	chk_index_preset: assert property (index |=> cnt_reg == PRESET_S) // see RL1
		else $error("counter not preset on index");
	chk_prop_clamp: assert property (sample && fast |=> prop_reg == 6'h1F // see RL4
		&& BOOST) else $error("fast remainder not clamped");
	chk_boost_slow: assert property (sample && slow |=> BOOST ##1 // see RL5
		ctrl_reg == 8'hFF) else $error("slow overflow gave no boost");
	chk_stall_set: assert property (at_floor && !index |=> stall_reg ##1 FAULT) // see RL8
		else $error("stall not declared at timeout");
	chk_stall_hold: assert property (stall_reg [*2] |-> // see RL9
		PHASE_A_DRIVE == 8'h00 && PHASE_B_DRIVE == 8'h00 && PHASE_C_DRIVE == 8'h00)
		else $error("current not zero while stalled");
	chk_stall_fault: assert property (stall_reg [*2] |-> FAULT) // see RL10
		else $error("fault dropped during stall");
	chk_supply_off: assert property (supply_bad |=> FAULT && PHASE_A_DRIVE == 8'h00 // see RL11
		&& PHASE_B_DRIVE == 8'h00 && PHASE_C_DRIVE == 8'h00)
		else $error("low supply did not stop drivers");
	chk_lock_range: assert property (sample && !fast && !slow && !at_floor // see RL13
		|=> LOCK_OE && !LOCK_O) else $error("lock not pulled in range");
	chk_brake_off: assert property (brake_stop_reg |=> PHASE_A_DRIVE == 8'h00 // see RL15
		&& PHASE_B_DRIVE == 8'h00 && PHASE_C_DRIVE == 8'h00)
		else $error("drivers on after brake stop");
	chk_commut_sel: assert property (!drv_off && hall_eff == 3'b010 // see RL17
		|=> PHASE_A_DRIVE == 8'h00 && PHASE_C_DRIVE == 8'h00)
		else $error("wrong phase driven");

	cov_stall: cover property (stall_reg ##[1:20] index);
	cov_lock: cover property ($rose(lock_reg));
	cov_brake: cover property (braking ##1 brake_stop_reg);
	cov_boost: cover property (sample && slow);
endmodule : sslc_core
`default_nettype wire

/* File: testbench/sslc_motor_model.sv */
// motor side model: reference oscillator, hall sensors, power transistors
`timescale 1ns/1ps
`default_nettype none
module sslc_motor_model (
	input  wire logic             ref_run,  // oscillator running
	input  wire logic [2:0]       hall_pos, // rotor sector, halls {3,2,1}
	input  wire logic [23:0]      drv,      // base drives {c,b,a}
	output var logic              ref_clk,  // 2 MHz reference
	output logic [2:0]            hall,     // pulled-up hall levels
	output sslc_pkg::sslc_phase_t phase_on  // conducting transistor
);
	// no free run: a dead oscillator holds its level, so loss is visible
	initial ref_clk = 1'b0;
	always #250 if (ref_run) ref_clk = ~ref_clk;
	// ideal hall switches, no bounce modelled
	assign hall = hall_pos;
	// only a lone live base conducts; two at once reads as none
	always_comb begin
		phase_on = sslc_pkg::PH_NONE;
		if (drv[7:0] != 8'h00 && drv[23:8] == 16'h0000) phase_on = sslc_pkg::PH_A;
		if (drv[15:8] != 8'h00 && {drv[23:16], drv[7:0]} == 16'h0000) phase_on = sslc_pkg::PH_B;
		if (drv[23:16] != 8'h00 && drv[15:0] == 16'h0000) phase_on = sslc_pkg::PH_C;
	end
endmodule : sslc_motor_model
`default_nettype wire

/* File: testbench/spindle_speed_loop_control_tb.sv */
// self-checking bench of the spindle speed loop controller
`timescale 1ns/1ps
`default_nettype none
module spindle_speed_loop_control_tb;
	logic                  clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]            paddr = 8'h00, drv_a, drv_b, drv_c;
	logic [31:0]           pwdata = 32'h0000_0000, prdata, rd;
	logic                  ref_run = 1'b1, run_brake = 1'b1, supply_low = 1'b0, pready, pslverr;
	logic [2:0]            hall_pos = 3'b010, hall;
	logic                  err, ref_clk, hall_bias, boost, fault, lock_o, lock_oe, irq;
	sslc_pkg::sslc_loop_t  loop_dac;
	sslc_pkg::sslc_phase_t phase_on;
	int                    bad_count = 0, check_count = 0, n, i;
	// 250 MHz system clock
	always #2 clk = ~clk;
	// short stall and loss counts keep the run brief
	sslc_core #(.STALL_TICKS(100), .REF_LOSS_CYC(200)) dut (
		.CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .REFERENCE_CLOCK_IN(ref_clk),
		.INDEX_HALL_INPUT(hall[0]), .SECOND_HALL_INPUT(hall[1]),
		.THIRD_HALL_INPUT(hall[2]), .RUN_BRAKE(run_brake), .SUPPLY_LOW(supply_low),
		.HALL_BIAS_OUTPUT(hall_bias), .PHASE_A_DRIVE(drv_a), .PHASE_B_DRIVE(drv_b),
		.PHASE_C_DRIVE(drv_c), .LOOP_DAC(loop_dac), .BOOST(boost), .FAULT(fault),
		.LOCK_O(lock_o), .LOCK_OE(lock_oe), .IRQ(irq));
	sslc_motor_model motor (.ref_run(ref_run), .hall_pos(hall_pos),
		.drv({drv_c, drv_b, drv_a}), .ref_clk(ref_clk), .hall(hall), .phase_on(phase_on));
	// one comparison, counted
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// apb transfer; waits for pready, the watchdog bounds a hang
	// one idle edge after release so registered effects have settled on return
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	// rotor step: move to a sector, let syncs and pipeline settle
	task automatic step(input logic [2:0] p, input int cyc);
		hall_pos <= p;
		repeat (cyc) @(posedge clk);
	endtask : step
	// counts and verdict, the only end of the run
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : results
	// register access kinds and error answers
	task automatic t_regs;
		apb(1'b0, sslc_pkg::OFS_CTRL, 32'h0000_0000);
		chk("hall bias", 1, hall_bias);
		chk("ctrl reset", 32'h0000_0001, rd);
		apb(1'b1, sslc_pkg::OFS_CTRL, 32'h0000_0000);
		repeat (2) @(posedge clk);
		chk("drive disabled", sslc_pkg::PH_NONE, phase_on);
		apb(1'b1, sslc_pkg::OFS_CTRL, 32'h0000_0001);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk("unmapped err", 1, err);
		apb(1'b1, sslc_pkg::OFS_STATE, 32'h0000_00FF);
		chk("ro write err", 1, err);
		$display("test regs done");
	endtask : t_regs
	// commutation table at start amplitude; 101 gives the first index only
	task automatic t_phase;
		logic [2:0] pos [6] = '{3'b010, 3'b110, 3'b100, 3'b101, 3'b001, 3'b011};
		for (i = 0; i < 6; i++) begin
			step(pos[i], 12);
			chk("phase", ((i / 2 + 1) % 3) + 1, phase_on);
			chk("start amp", 8'hFF, drv_a | drv_b | drv_c);
		end
		$display("test phase done");
	endtask : t_phase
	// early index: remainder far above range clamps at the fast end
	task automatic t_fast;
		step(3'b100, 1250);
		step(3'b101, 12);
		chk("prop", 6'h1F, loop_dac.prop);
		chk("integ", 8'h10, loop_dac.integ);
		chk("boost", 1, boost);
		chk("lock", 0, lock_oe);
		chk("lock pin", 0, lock_o);
		chk("amp", 8'h51, drv_c);
		$display("test fast done");
	endtask : t_fast
	// braking reverses phasing; motor is turning, so braking is allowed
	task automatic t_brake;
		run_brake <= 1'b0;
		repeat (12) @(posedge clk);
		chk("brake phase", sslc_pkg::PH_B, phase_on);
		run_brake <= 1'b1;
		repeat (12) @(posedge clk);
		chk("run phase", sslc_pkg::PH_C, phase_on);
		$display("test brake done");
	endtask : t_brake
	// no index: stall, interrupt, hold, then one index releases
	task automatic t_stall;
		apb(1'b1, sslc_pkg::OFS_IRQ_CLR, 32'h0000_003F);
		apb(1'b1, sslc_pkg::OFS_IRQ_EN, 32'h0000_0001);
		chk("irq idle", 0, irq);
		n = 0;
		while (fault !== 1'b1 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		chk("stall delay", 1, n > 10000);
		chk("stall fault", 1, fault);
		repeat (4) @(posedge clk);
		chk("stall off", sslc_pkg::PH_NONE, phase_on);
		chk("stall irq", 1, irq);
		apb(1'b0, sslc_pkg::OFS_STATE, 32'h0000_0000);
		chk("stall bit", 1, rd[1]);
		apb(1'b1, sslc_pkg::OFS_IRQ_EN, 32'h0000_0000);
		chk("irq masked", 0, irq);
		apb(1'b1, sslc_pkg::OFS_IRQ_CLR, 32'h0000_0001);
		apb(1'b0, sslc_pkg::OFS_IRQ_STAT, 32'h0000_0000);
		chk("irq cleared", 0, rd[0]);
		step(3'b100, 500);
		chk("stall hold", sslc_pkg::PH_NONE, phase_on);
		step(3'b101, 12);
		chk("stall release", 0, fault);
		$display("test stall done");
	endtask : t_stall
	// low supply, then a dead reference
	task automatic t_faults;
		supply_low <= 1'b1;
		repeat (10) @(posedge clk);
		chk("supply fault", 1, fault);
		chk("supply off", sslc_pkg::PH_NONE, phase_on);
		supply_low <= 1'b0;
		repeat (10) @(posedge clk);
		chk("supply back", 0, fault);
		ref_run <= 1'b0;
		repeat (400) @(posedge clk);
		chk("ref fault", 1, fault);
		chk("ref off", sslc_pkg::PH_NONE, phase_on);
		$display("test faults done");
	endtask : t_faults
	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		t_regs();
		t_phase();
		t_fast();
		t_brake();
		t_stall();
		t_faults();
		results();
	end
	// watchdog: whole run is about 60 us
	initial begin
		#300000;
		bad_count++;
		$display("MISMATCH watchdog expected done seen hang");
		results();
	end
endmodule : spindle_speed_loop_control_tb
`default_nettype wire
